/* verilog/dci_regs.svh */
// Constants for the dual-core two-wire register slave and its master
`ifndef DCI_REGS_SVH
`define DCI_REGS_SVH

// Seven-bit slave addresses of the two cores
`define DCI_ACC_ADDR 7'h19
`define DCI_MAG_ADDR 7'h1e

// Position of the auto-increment request in the sub-address byte
`define DCI_SUB_INC_BIT 7

// Valid register locations
`define DCI_ACC_LO 7'h20
`define DCI_ACC_HI 7'h3d
`define DCI_MAG_HI0 7'h0c
`define DCI_MAG_LO1 7'h31
`define DCI_MAG_HI1 7'h32

// Magnetic core pointer wrap points
`define DCI_MAG_WRAP_AT 7'h08
`define DCI_MAG_WRAP_TO 7'h03
`define DCI_MAG_LIMIT 7'h0c

// Bit count at which a byte is complete
`define DCI_BYTE_ACK 4'h8

// Timing of the master's bus clock: 400 kHz keeps bench runs short
`define DCI_MCLK_NS 10
`define DCI_SCL_NS 2500
`define DCI_QTR_CYC ((`DCI_SCL_NS / 4 + `DCI_MCLK_NS - 1) / `DCI_MCLK_NS)
`define DCI_QTR_W 9

`endif

/* verilog/dci_pkg.sv */
// Types shared by both ends of the dual-core two-wire link
package dci_pkg;
	typedef enum logic {CORE_ACC = 1'b0, CORE_MAG = 1'b1} dci_core_t;
	typedef enum logic [1:0] {
		PH_ADDR = 2'h0,
		PH_SUB = 2'h1,
		PH_DATA = 2'h3
	} dci_phase_t;
	typedef enum logic [2:0] {
		DS_IDLE = 3'h0,
		DS_RX = 3'h1,
		DS_ACK = 3'h3,
		DS_TX = 3'h2,
		DS_MACK = 3'h6
	} dci_dev_st_t;
	typedef enum logic [1:0] {
		HS_IDLE = 2'h0,
		HS_START = 2'h1,
		HS_XFER = 2'h3,
		HS_STOP = 2'h2
	} dci_host_st_t;
	typedef enum logic [2:0] {
		STEP_ADDRW = 3'h0,
		STEP_SUB = 3'h1,
		STEP_WDATA = 3'h3,
		STEP_ADDRR = 3'h2,
		STEP_RDATA = 3'h6
	} dci_step_t;
endpackage : dci_pkg

/* verilog/dci_link_if.sv */
// Open-drain two-wire link joining the master and the dual-core slave
`timescale 1ns/10ps
interface dci_link_if;
	logic scl_m_o;
	logic scl_m_oe_n;
	logic sda_m_o;
	logic sda_m_oe_n;
	logic scl_s_o;
	logic scl_s_oe_n;
	logic sda_s_o;
	logic sda_s_oe_n;
	logic scl;
	logic sda;

	// Released lines float high through the pull-ups
	assign scl = (scl_m_oe_n | scl_m_o) & (scl_s_oe_n | scl_s_o);
	assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

	modport master (
		output scl_m_o,
		output scl_m_oe_n,
		output sda_m_o,
		output sda_m_oe_n,
		input scl,
		input sda
	);
	modport slave (
		output scl_s_o,
		output scl_s_oe_n,
		output sda_s_o,
		output sda_s_oe_n,
		input scl,
		input sda
	);
endinterface : dci_link_if

/* verilog/dci_host.sv */
// Master end: drives the bus clock and runs register writes and reads
`timescale 1ns/10ps
`include "dci_regs.svh"
module dci_host (
	dci_link_if.master link,
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [6:0] cmd_dev,
	input wire logic [7:0] cmd_sub,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_len,
	input wire logic [7:0] wr_data,
	output logic wr_take,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic done,
	output logic nack,
	output logic busy
);
	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;
	logic scl_f_q;
	logic sda_f_q;
	logic [`DCI_QTR_W-1:0] div_q;
	logic tick;
	logic stall;
	dci_pkg::dci_host_st_t st_q;
	dci_pkg::dci_step_t step_q;
	logic [1:0] qtr_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [7:0] left_q;
	logic [6:0] dev_q;
	logic [7:0] sub_q;
	logic rd_q;
	logic scl_rel_q;
	logic sda_rel_q;
	logic sending;
	logic last;

	assign link.scl_m_o = 1'b0;
	assign link.sda_m_o = 1'b0;
	assign link.scl_m_oe_n = scl_rel_q;
	assign link.sda_m_oe_n = sda_rel_q;
	assign cmd_ready = (st_q == dci_pkg::HS_IDLE);
	assign busy = ~cmd_ready;
	assign sending = (step_q != dci_pkg::STEP_RDATA);
	assign last = (left_q == 8'h01);
	// A released clock held low by the slave freezes the quarter timer
	assign stall = scl_rel_q & ~scl_f_q; // R13
	assign tick = (div_q == `DCI_QTR_W'(`DCI_QTR_CYC - 1)) & ~stall;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
		end
		else
		begin
			scl_s_q <= {scl_s_q[1:0], link.scl};
			sda_s_q <= {sda_s_q[1:0], link.sda};
			if (scl_s_q[1] == scl_s_q[2])
				scl_f_q <= scl_s_q[2];
			if (sda_s_q[1] == sda_s_q[2])
				sda_f_q <= sda_s_q[2];
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			div_q <= '0;
		else if (st_q == dci_pkg::HS_IDLE || tick)
			div_q <= '0;
		else if (!stall)
			div_q <= div_q + `DCI_QTR_W'(1);
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= dci_pkg::HS_IDLE;
			step_q <= dci_pkg::STEP_ADDRW;
			qtr_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			left_q <= 8'h00;
			dev_q <= 7'h00;
			sub_q <= 8'h00;
			rd_q <= 1'b0;
			scl_rel_q <= 1'b1;
			sda_rel_q <= 1'b1;
			wr_take <= 1'b0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			done <= 1'b0;
			nack <= 1'b0;
		end
		else
		begin
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			done <= 1'b0;
			case (st_q)
				dci_pkg::HS_IDLE:
				begin
					if (cmd_valid)
					begin
						st_q <= dci_pkg::HS_START;
						step_q <= dci_pkg::STEP_ADDRW;
						qtr_q <= 2'h0;
						dev_q <= cmd_dev;
						sub_q <= cmd_sub;
						rd_q <= cmd_rd;
						left_q <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
						sh_q <= {cmd_dev, 1'b0}; // R3
						nack <= 1'b0;
						scl_rel_q <= 1'b0;
					end
				end
				dci_pkg::HS_START:
				begin
					if (tick)
					begin
						qtr_q <= qtr_q + 2'h1;
						case (qtr_q)
							2'h0: sda_rel_q <= 1'b1;
							2'h1: scl_rel_q <= 1'b1;
							// Data falls while the clock is high
							2'h2: sda_rel_q <= 1'b0; // R16
							default:
							begin
								st_q <= dci_pkg::HS_XFER;
								bit_q <= 4'h0;
								scl_rel_q <= 1'b0;
							end
						endcase
					end
				end
				dci_pkg::HS_XFER:
				begin
					if (tick)
					begin
						qtr_q <= qtr_q + 2'h1;
						case (qtr_q)
							2'h0:
							begin
								// Data changes only while the clock is low
								if (bit_q != `DCI_BYTE_ACK)
									sda_rel_q <= sending ? sh_q[7] : 1'b1; // R12
								else
									sda_rel_q <= sending | last; // R11
							end
							2'h1: scl_rel_q <= 1'b1;
							2'h2: scl_rel_q <= 1'b1;
							default:
							begin
								scl_rel_q <= 1'b0;
								bit_q <= bit_q + 4'h1;
								if (bit_q != `DCI_BYTE_ACK)
									sh_q <= {sh_q[6:0], sda_f_q};
								else if (sending && sda_f_q)
								begin
									st_q <= dci_pkg::HS_STOP; // R14
									nack <= 1'b1;
								end
								else
								begin
									bit_q <= 4'h0;
									case (step_q)
										dci_pkg::STEP_ADDRW:
										begin
											step_q <= dci_pkg::STEP_SUB; // R7
											sh_q <= sub_q;
										end
										dci_pkg::STEP_SUB:
										begin
											if (rd_q)
											begin
												st_q <= dci_pkg::HS_START; // R19
												step_q <= dci_pkg::STEP_ADDRR;
												sh_q <= {dev_q, 1'b1};
											end
											else
											begin
												step_q <= dci_pkg::STEP_WDATA; // R10
												sh_q <= wr_data;
												wr_take <= 1'b1;
											end
										end
										dci_pkg::STEP_WDATA:
										begin
											left_q <= left_q - 8'h01;
											sh_q <= wr_data;
											wr_take <= ~last;
											if (last)
												st_q <= dci_pkg::HS_STOP;
										end
										dci_pkg::STEP_ADDRR:
											step_q <= dci_pkg::STEP_RDATA;
										default:
										begin
											rd_data <= sh_q;
											rd_valid <= 1'b1;
											left_q <= left_q - 8'h01;
											if (last)
												st_q <= dci_pkg::HS_STOP;
										end
									endcase
								end
							end
						endcase
					end
				end
				dci_pkg::HS_STOP:
				begin
					if (tick)
					begin
						qtr_q <= qtr_q + 2'h1;
						case (qtr_q)
							2'h0: sda_rel_q <= 1'b0;
							2'h1: scl_rel_q <= 1'b1;
							// Data rises while the clock is high
							2'h2: sda_rel_q <= 1'b1; // R15
							default:
							begin
								st_q <= dci_pkg::HS_IDLE;
								done <= 1'b1;
							end
						endcase
					end
				end
				default: st_q <= dci_pkg::HS_IDLE;
			endcase
		end
	end
endmodule : dci_host

/* verilog/dci_slave.sv */
// Device end: dual-address register slave on the two-wire link
`timescale 1ns/10ps
`include "dci_regs.svh"
// Functional notes
// R1: Slave only; register writes and readback.
// R2: Two slave addresses, one per core.
// R3: First byte: seven address bits, direction bit.
// R4: Selected only on exact address match.
// R5: Sender releases data; receiver holds low.
// R6: Acknowledge every received byte once addressed.
// R7: Sub-address: low seven register, top increment.
// R8: Top bit set advances address per byte.
// R9: Master sets increment bit for bursts; dci_host sends cmd_sub as given, bit 7 unchanged.
// R10: Write: start, address, sub, data, stop.
// R11: Read: repeated start; last byte not acknowledged.
// R12: Bytes of eight bits, MSB first, unlimited.
// R13: Receiver may stretch clock low to stall; dci_slave stretches only as sender, while read data is not yet loaded.
// R14: Unmatched slave leaves data line high.
// R15: Master ends with data rise, clock high.
// R16: Start is data fall, clock high.
// R17: Acceleration core answers address 0011001b.
// R18: Magnetic core answers address 0011110b.
// R19: Reads resend address with direction one.
// R20: Magnetic pointer: 08 to 03, 12+ to 0.
// R21: Magnetic pointer never readable over bus.
// R22: Invalid reads give zero; invalid writes dropped.
// R23: Acceleration increment is exactly one per byte.
module dci_slave (
	dci_link_if.slave link,
	input wire logic lclk,
	input wire logic mclk,
	input wire logic arst_n,
	output logic usr_wr_stb,
	output logic usr_rd_stb,
	output dci_pkg::dci_core_t usr_core,
	output logic [6:0] usr_addr,
	output logic [7:0] usr_wdata,
	input wire logic [7:0] usr_rdata
);
	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;
	logic scl_f_q;
	logic sda_f_q;
	logic scl_p_q;
	logic sda_p_q;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	dci_pkg::dci_dev_st_t st_q;
	dci_pkg::dci_phase_t phase_q;
	dci_pkg::dci_core_t core_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic [6:0] ptr_q;
	logic inc_q;
	logic rw_q;
	logic loaded_q;
	logic mack_q;
	logic byte_end;
	logic iss_rd;
	logic iss_wr;
	logic loc_ok;
	logic req_tgl_q;
	logic req_wr_q;
	dci_pkg::dci_core_t req_core_q;
	logic [6:0] req_addr_q;
	logic [7:0] req_data_q;
	logic [2:0] ack_s_q;
	logic ack_evt;
	logic rd_rdy_q;
	logic [7:0] rd_buf_q;
	logic [2:0] req_s_q;
	logic req_evt;
	logic ack_tgl_q;
	logic [7:0] rd_hold_q;

	function automatic logic [6:0] next_ptr(
		input dci_pkg::dci_core_t c,
		input logic inc,
		input logic [6:0] p
	);
		logic [6:0] n;
		n = p;
		if (c == dci_pkg::CORE_MAG)
		begin
			if (p == `DCI_MAG_WRAP_AT)
				n = `DCI_MAG_WRAP_TO; // R20
			else if (p >= `DCI_MAG_LIMIT)
				n = 7'h00; // R20
			else
				n = p + 7'h01;
		end
		else if (inc)
			n = p + 7'h01; // R8 R23
		return n;
	endfunction : next_ptr

	function automatic logic valid_loc(
		input dci_pkg::dci_core_t c,
		input logic [6:0] p
	);
		if (c == dci_pkg::CORE_MAG)
			return (p <= `DCI_MAG_HI0) ||
				((p >= `DCI_MAG_LO1) && (p <= `DCI_MAG_HI1));
		return (p >= `DCI_ACC_LO) && (p <= `DCI_ACC_HI);
	endfunction : valid_loc

	// Pins are sampled on the fast link-side clock and filtered
	always_ff @(posedge lclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_s_q <= {scl_s_q[1:0], link.scl};
			sda_s_q <= {sda_s_q[1:0], link.sda};
			if (scl_s_q[1] == scl_s_q[2])
				scl_f_q <= scl_s_q[2];
			if (sda_s_q[1] == sda_s_q[2])
				sda_f_q <= sda_s_q[2];
			scl_p_q <= scl_f_q;
			sda_p_q <= sda_f_q;
		end
	end

	assign scl_rise = scl_f_q & ~scl_p_q;
	assign scl_fall = ~scl_f_q & scl_p_q;
	assign start_c = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q; // R16
	assign stop_c = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q; // R15
	assign byte_end = (st_q == dci_pkg::DS_RX) & scl_fall &
		(bit_q == `DCI_BYTE_ACK) & ~start_c & ~stop_c;
	assign iss_wr = byte_end & (phase_q == dci_pkg::PH_DATA); // R10
	assign iss_rd = scl_fall & ~start_c & ~stop_c &
		(((st_q == dci_pkg::DS_ACK) & (phase_q == dci_pkg::PH_ADDR) & rw_q) |
		((st_q == dci_pkg::DS_MACK) & mack_q));
	assign loc_ok = valid_loc(core_q, ptr_q);

	// Open-drain: only ever pull low, otherwise release
	assign link.scl_s_o = 1'b0;
	assign link.sda_s_o = 1'b0;
	assign link.scl_s_oe_n = ~((st_q == dci_pkg::DS_TX) & ~loaded_q); // R13
	assign link.sda_s_oe_n = ~((st_q == dci_pkg::DS_ACK) |
		((st_q == dci_pkg::DS_TX) & loaded_q & ~sh_q[7])); // R5 R6

	always_ff @(posedge lclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= dci_pkg::DS_IDLE;
			phase_q <= dci_pkg::PH_ADDR;
			core_q <= dci_pkg::CORE_ACC;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 7'h00;
			inc_q <= 1'b0;
			rw_q <= 1'b0;
			loaded_q <= 1'b0;
			mack_q <= 1'b0;
		end
		else if (stop_c)
			st_q <= dci_pkg::DS_IDLE;
		else if (start_c)
		begin
			st_q <= dci_pkg::DS_RX;
			phase_q <= dci_pkg::PH_ADDR;
			bit_q <= 4'h0;
		end
		else
		begin
			case (st_q)
				dci_pkg::DS_RX:
				begin
					if (scl_rise && bit_q != `DCI_BYTE_ACK)
					begin
						sh_q <= {sh_q[6:0], sda_f_q}; // R12
						bit_q <= bit_q + 4'h1;
					end
					else if (byte_end)
					begin
						st_q <= dci_pkg::DS_ACK; // R6
						case (phase_q)
							dci_pkg::PH_ADDR:
							begin
								rw_q <= sh_q[0]; // R3
								if (sh_q[7:1] == `DCI_ACC_ADDR)
									core_q <= dci_pkg::CORE_ACC; // R17
								else if (sh_q[7:1] == `DCI_MAG_ADDR)
									core_q <= dci_pkg::CORE_MAG; // R18
								else
									st_q <= dci_pkg::DS_IDLE; // R4 R14
							end
							dci_pkg::PH_SUB:
							begin
								ptr_q <= sh_q[6:0]; // R7
								inc_q <= sh_q[`DCI_SUB_INC_BIT];
							end
							default: ptr_q <= next_ptr(core_q, inc_q, ptr_q);
						endcase
					end
				end
				dci_pkg::DS_ACK:
				begin
					if (scl_fall)
					begin
						bit_q <= 4'h0;
						if (iss_rd)
						begin
							st_q <= dci_pkg::DS_TX; // R1
							loaded_q <= 1'b0;
						end
						else
						begin
							st_q <= dci_pkg::DS_RX;
							if (phase_q == dci_pkg::PH_ADDR)
								phase_q <= dci_pkg::PH_SUB;
							else
								phase_q <= dci_pkg::PH_DATA;
						end
					end
				end
				dci_pkg::DS_TX:
				begin
					if (!loaded_q)
					begin
						if (rd_rdy_q)
						begin
							sh_q <= rd_buf_q;
							loaded_q <= 1'b1;
							bit_q <= 4'h0;
						end
					end
					else if (scl_fall)
					begin
						sh_q <= {sh_q[6:0], 1'b1};
						bit_q <= bit_q + 4'h1;
						if (bit_q == 4'h7)
						begin
							st_q <= dci_pkg::DS_MACK; // R5
							ptr_q <= next_ptr(core_q, inc_q, ptr_q); // R8
						end
					end
				end
				dci_pkg::DS_MACK:
				begin
					if (scl_rise)
						mack_q <= ~sda_f_q;
					else if (scl_fall)
					begin
						loaded_q <= 1'b0;
						st_q <= mack_q ? dci_pkg::DS_TX : dci_pkg::DS_IDLE; // R11
					end
				end
				default: st_q <= dci_pkg::DS_IDLE;
			endcase
		end
	end

	// Bundle stays stable until the next request, well after the ack
	always_ff @(posedge lclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			req_tgl_q <= 1'b0;
			req_wr_q <= 1'b0;
			req_core_q <= dci_pkg::CORE_ACC;
			req_addr_q <= 7'h00;
			req_data_q <= 8'h00;
		end
		else if ((iss_rd || iss_wr) && loc_ok)
		begin
			req_tgl_q <= ~req_tgl_q; // R22
			req_wr_q <= iss_wr;
			req_core_q <= core_q;
			req_addr_q <= ptr_q;
			req_data_q <= sh_q;
		end
	end

	always_ff @(posedge lclk or negedge arst_n)
	begin
		if (!arst_n)
			ack_s_q <= 3'h0;
		else
			ack_s_q <= {ack_s_q[1:0], ack_tgl_q};
	end

	assign ack_evt = ack_s_q[1] ^ ack_s_q[2];

	// Only register contents or zero are ever loaded, never the pointer
	always_ff @(posedge lclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_rdy_q <= 1'b0;
			rd_buf_q <= 8'h00;
		end
		else if (iss_rd)
		begin
			rd_rdy_q <= ~loc_ok;
			rd_buf_q <= 8'h00; // R21 R22
		end
		else if (ack_evt && !req_wr_q)
		begin
			rd_rdy_q <= 1'b1;
			rd_buf_q <= rd_hold_q;
		end
		else if (st_q == dci_pkg::DS_TX && !loaded_q)
			rd_rdy_q <= 1'b0;
	end

	// Register-side half of the toggle handshake
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			req_s_q <= 3'h0;
		else
			req_s_q <= {req_s_q[1:0], req_tgl_q};
	end

	assign req_evt = req_s_q[1] ^ req_s_q[2];

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			usr_wr_stb <= 1'b0;
			usr_rd_stb <= 1'b0;
			usr_core <= dci_pkg::CORE_ACC;
			usr_addr <= 7'h00;
			usr_wdata <= 8'h00;
		end
		else
		begin
			usr_wr_stb <= req_evt & req_wr_q;
			usr_rd_stb <= req_evt & ~req_wr_q;
			if (req_evt)
			begin
				usr_core <= req_core_q; // R2
				usr_addr <= req_addr_q;
				usr_wdata <= req_data_q;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_tgl_q <= 1'b0;
			rd_hold_q <= 8'h00;
		end
		else if (usr_wr_stb || usr_rd_stb)
		begin
			ack_tgl_q <= ~ack_tgl_q;
			if (usr_rd_stb)
				rd_hold_q <= usr_rdata;
		end
	end
endmodule : dci_slave

/* test/dci_link_properties.sv */
// Link-level checks between the two-wire master and the dual-core slave
`timescale 1ns/10ps
`include "dci_regs.svh"
module dci_link_properties (
	input logic mclk,
	input logic arst_n,
	input logic scl_m_o,
	input logic scl_m_oe_n,
	input logic sda_m_o,
	input logic sda_m_oe_n,
	input logic scl_s_o,
	input logic scl_s_oe_n,
	input logic sda_s_o,
	input logic sda_s_oe_n,
	input logic scl,
	input logic sda
);
	logic scl_q, sda_q, seen_q, hit_q, rd_q;
	logic [3:0] bit_q;
	logic [2:0] byte_q;
	logic [6:0] sh_q;
	logic rise, edge_st, edge_sp, ack_hi;

	assign rise = scl & ~scl_q;
	assign edge_st = scl & scl_q & sda_q & ~sda;
	assign edge_sp = scl & scl_q & ~sda_q & sda;
	// Ninth clock high phase; scl_q skips the rise cycle, seen_q a start
	assign ack_hi = scl & scl_q & seen_q & (bit_q == 4'h0);

	default clocking cb_m @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
		end

	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			bit_q <= 4'h0;
			byte_q <= 3'h0;
			seen_q <= 1'h0;
		end
		else if (edge_st)
		begin
			bit_q <= 4'h0;
			byte_q <= 3'h0;
			seen_q <= 1'h0;
		end
		else if (rise)
		begin
			bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
			seen_q <= 1'h1;
			if (bit_q == 4'h7 && byte_q != 3'h7)
				byte_q <= byte_q + 3'h1;
		end

	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			sh_q <= 7'h00;
			hit_q <= 1'h0;
			rd_q <= 1'h0;
		end
		else if (edge_st || edge_sp)
			hit_q <= 1'h0;
		else if (rise && bit_q != 4'h8)
		begin
			sh_q <= {sh_q[5:0], sda};
			if (bit_q == 4'h7 && byte_q == 3'h0)
			begin
				hit_q <= sh_q == `DCI_ACC_ADDR || sh_q == `DCI_MAG_ADDR;
				rd_q <= sda;
			end
		end

	a_open_drain:
	assert property (!(scl_m_o | sda_m_o | scl_s_o | sda_s_o))
		else $error("a link driver output is high");
	a_slave_ack_low:
	assert property (ack_hi && hit_q && (!rd_q || byte_q == 3'h1)
		|-> !sda_s_oe_n && !sda) else $error("slave did not acknowledge");
	a_nomatch_high:
	assert property (ack_hi && !hit_q && byte_q == 3'h1 |-> sda && sda_s_oe_n)
		else $error("unaddressed slave pulled data low");
	a_unselected_quiet:
	assert property (!hit_q |-> sda_s_oe_n && scl_s_oe_n)
		else $error("slave drives the link while not selected");
	a_tx_release_ack:
	assert property (ack_hi && hit_q && rd_q && byte_q > 3'h1 |-> sda_s_oe_n)
		else $error("sending slave kept data during acknowledge");
	a_master_release_ack:
	assert property (ack_hi && (!rd_q || byte_q == 3'h1) |-> sda_m_oe_n)
		else $error("sending master kept data during acknowledge");
	a_slave_sda_still:
	assert property (scl && scl_q |-> $stable(sda_s_oe_n))
		else $error("slave moved data while clock high");
	a_stretch_short:
	assert property ($fell(scl_s_oe_n) |-> !scl_q ##[1:400] scl_s_oe_n)
		else $error("slave clock stretch misplaced or too long");

	c_write_ack: cover property (ack_hi && hit_q && !rd_q && byte_q == 3'h3);
	c_read_ack: cover property (ack_hi && hit_q && rd_q && byte_q == 3'h3);
	c_nomatch: cover property (ack_hi && !hit_q && byte_q == 3'h1);
	c_stretch: cover property ($fell(scl_s_oe_n));
endmodule : dci_link_properties

/* test/tb.sv */
// Self-checking bench: master and dual-core slave joined over the link
`timescale 1ns/10ps
`include "dci_regs.svh"
module tb;
	logic mclk = 1'h0;
	logic lclk = 1'h0;
	logic arst_n = 1'h0;
	logic cmd_valid = 1'h0;
	logic cmd_rd = 1'h0;
	logic [6:0] cmd_dev = 7'h00;
	logic [7:0] cmd_sub = 8'h00;
	logic [7:0] cmd_len = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic cmd_ready, wr_take, rd_valid, done, nack, busy;
	logic usr_wr_stb, usr_rd_stb;
	logic [7:0] rd_data, usr_wdata, usr_rdata;
	logic [6:0] usr_addr;
	dci_pkg::dci_core_t usr_core;
	logic [7:0] acc_mem [128];
	logic [7:0] mag_mem [128];
	logic [7:0] wq [$];
	logic [7:0] rd_exp [$];
	logic [15:0] wr_exp [$];
	logic [15:0] e;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n_rd_req = 0;
	int cycles = 0;
	int seed = 32'h29bf3ed3;

	always #5 mclk = ~mclk;
	// Odd offset keeps link clock edges off the system clock edges
	initial
	begin
		#1.3;
		forever #3 lclk = ~lclk;
	end

	// User-side register storage answers in the strobe cycle
	assign usr_rdata = (usr_core == dci_pkg::CORE_MAG) ? mag_mem[usr_addr]
		: acc_mem[usr_addr];

	dci_link_if link ();
	dci_host u_dci_host (.link(link), .mclk(mclk), .arst_n(arst_n),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_dev(cmd_dev),
		.cmd_sub(cmd_sub), .cmd_rd(cmd_rd), .cmd_len(cmd_len),
		.wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
		.rd_valid(rd_valid), .done(done), .nack(nack), .busy(busy));
	dci_slave u_dci_slave (.link(link), .lclk(lclk), .mclk(mclk),
		.arst_n(arst_n), .usr_wr_stb(usr_wr_stb), .usr_rd_stb(usr_rd_stb),
		.usr_core(usr_core), .usr_addr(usr_addr), .usr_wdata(usr_wdata),
		.usr_rdata(usr_rdata));
	dci_link_properties u_dci_link_properties (.mclk(mclk), .arst_n(arst_n),
		.scl_m_o(link.scl_m_o), .scl_m_oe_n(link.scl_m_oe_n),
		.sda_m_o(link.sda_m_o), .sda_m_oe_n(link.sda_m_oe_n),
		.scl_s_o(link.scl_s_o), .scl_s_oe_n(link.scl_s_oe_n),
		.sda_s_o(link.sda_s_o), .sda_s_oe_n(link.sda_s_oe_n),
		.scl(link.scl), .sda(link.sda));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	function automatic logic ok_loc(input logic c, input logic [6:0] p);
		if (c)
			return p <= 7'h0c || p == 7'h31 || p == 7'h32;
		return p >= 7'h20 && p <= 7'h3d;
	endfunction : ok_loc

	function automatic logic [6:0] nxt(input logic c, input logic inc,
		input logic [6:0] p);
		if (!c)
			return inc ? p + 7'h01 : p;
		if (p == 7'h08)
			return 7'h03;
		if (p >= 7'h0c)
			return 7'h00;
		return p + 7'h01;
	endfunction : nxt

	// Entered one ns after a clock edge; returns the same way
	task automatic xfer(input logic [6:0] dev, input logic [7:0] sub,
		input logic rd, input logic [7:0] len, input logic want_nack);
		logic c;
		logic [6:0] p;
		logic [7:0] b;
		int k;
		int nv;
		c = (dev == `DCI_MAG_ADDR);
		p = sub[6:0];
		wq.delete();
		nv = 0;
		n_rd_req = 0;
		for (k = 0; k < len; k++)
		begin
			b = 8'($random(seed));
			wq.push_back(b);
			if (rd && ok_loc(c, p))
				nv++;
			if (!want_nack && rd)
				rd_exp.push_back(ok_loc(c, p) ? (c ? mag_mem[p] : acc_mem[p])
					: 8'h00);
			else if (!want_nack && ok_loc(c, p))
				wr_exp.push_back({c, p, b});
			p = nxt(c, sub[7], p);
		end
		wr_data = wq[0];
		cmd_dev = dev;
		cmd_sub = sub;
		cmd_rd = rd;
		cmd_len = len;
		cmd_valid = 1'h1;
		@(posedge mclk);
		#1;
		cmd_valid = 1'h0;
		check({15'h0000, busy}, 16'h0001);
		k = 0;
		while (done !== 1'h1 && k < 20000)
		begin
			@(posedge mclk);
			#1;
			k++;
		end
		// A transfer that never finishes counts against the run
		if (done !== 1'h1)
			n_mismatch++;
		check({15'h0000, cmd_ready}, 16'h0001);
		check({15'h0000, nack}, {15'h0000, want_nack});
		check(16'(wr_exp.size() + rd_exp.size()), 16'h0000);
		check(16'(n_rd_req), 16'(nv));
	endtask : xfer

	always @(posedge mclk)
		if (wr_take === 1'h1)
		begin
			#1;
			void'(wq.pop_front());
			wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
		end

	always @(posedge mclk)
	begin
		cycles++;
		if (usr_rd_stb === 1'h1)
			n_rd_req++;
		if (usr_wr_stb === 1'h1)
		begin
			e = (wr_exp.size() > 0) ? wr_exp.pop_front() : 16'hffff;
			check({usr_core, usr_addr, usr_wdata}, e);
			if (usr_core == dci_pkg::CORE_MAG)
				mag_mem[usr_addr] = usr_wdata;
			else
				acc_mem[usr_addr] = usr_wdata;
		end
		if (rd_valid === 1'h1)
		begin
			e = {8'h00, (rd_exp.size() > 0) ? rd_exp.pop_front() : 8'hxx};
			check({8'h00, rd_data}, e);
		end
		// Ceiling well above the five transfers at the fast bus clock
		if (cycles == 70000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial
	begin
		logic [6:0] d;
		for (int i = 0; i < 128; i++)
		begin
			acc_mem[i] = 8'($random(seed));
			mag_mem[i] = 8'($random(seed));
		end
		repeat (12) @(posedge mclk);
		#1;
		arst_n = 1'h1;
		repeat (3) @(posedge mclk);
		#1;
		// Second byte lands on an unused location and must be dropped
		xfer(`DCI_ACC_ADDR, 8'hbd, 1'h0, 8'h02, 1'h0);
		// Increment off: both bytes land on the same register
		xfer(`DCI_ACC_ADDR, 8'h21, 1'h0, 8'h02, 1'h0);
		xfer(`DCI_MAG_ADDR, 8'h08, 1'h1, 8'h02, 1'h0);
		// Burst readback that runs past the last valid location
		xfer(`DCI_ACC_ADDR, 8'hbc, 1'h1, 8'h03, 1'h0);
		d = 7'($random(seed));
		if (d == `DCI_ACC_ADDR || d == `DCI_MAG_ADDR)
			d = 7'h7f;
		xfer(d, 8'h20, 1'h0, 8'h01, 1'h1);
		wrap_up();
	end
endmodule : tb
